// ### rtl/ptsi_claim_if.sv
// Interface carrying claim information between status block modules
`timescale 1ns/1ps
interface ptsi_claim_if;
  import ptsi_pkg::*;
  logic [NUM_WIN-1:0] win_match;
  ptsi_pair_t         pair_mode;
  logic [NUM_WIN-1:0] win_hit;
  modport decoder (input win_match, input pair_mode, output win_hit);
  modport user    (output win_match, output pair_mode, input win_hit);
endinterface

// ### rtl/ptsi_pkg.sv
// Package of constants for the target status and interrupt block
package ptsi_pkg;
  // ----------------------------------------------------------------
  // Status bus layout
  // ----------------------------------------------------------------
  localparam int unsigned STATUS_W      = 12;
  localparam int unsigned NUM_WIN       = 6;
  localparam int unsigned BIT_WIN_LO    = 0;
  localparam int unsigned BIT_ROM_HIT   = 6;
  localparam int unsigned BIT_WIDE      = 7;
  localparam int unsigned BIT_ACCESS    = 8;
  localparam int unsigned BIT_BURST     = 9;
  localparam int unsigned BIT_XFER      = 10;
  localparam int unsigned BIT_DUAL_ADDR = 11;
  // Command register bit that masks the interrupt
  localparam int unsigned CMD_INT_DIS   = 10;
  localparam int unsigned CMD_W         = 16;
  // Window pairing modes
  typedef enum logic [1:0]
  {
    PTSI_PAIR_NONE = 2'b00,
    PTSI_PAIR_01   = 2'b01,
    PTSI_PAIR_12   = 2'b10
  } ptsi_pair_t;
  // Reset values
  localparam logic [STATUS_W-1:0] STATUS_RST = 12'h000;
  localparam logic                INTA_RST_N = 1'b1;
endpackage

// ### rtl/ptsi_top.sv
// Target transaction status bus and local interrupt forwarding
//
// Contract
// - Interrupt line active while local request low and interrupt-disable bit clear.
// - Status bits 5..0 flag the claimed base address window.
// - Windows 0 and 1 paired as 64-bit: both hit bits assert together.
// - Windows 1 and 2 paired as 64-bit: both hit bits assert together.
// - Status bit 6 flags an expansion ROM address match.
// - Wide variants: bit 7 high while the transaction is 64 bits wide.
// - 32-bit-only variants: bit 7 reserved, held low.
// - Status bit 8 high for the whole target access.
// - Status bit 9 marks burst: frame and irdy active in first data phase.
// - Status bit 10 pulses one cycle after each PCI-side data transfer of a claimed access.
// - Status bit 11 high while transaction used a dual address cycle.
`timescale 1ns/1ps
module ptsi_top
  import ptsi_pkg::*;
#(
  parameter bit WIDE_BUS = 1'b1
)
(
  input  wire logic                       clk_sys_i,
  input  wire logic                       reset_n_i,
  input  wire logic                       claim_start_i,
  input  wire logic                       access_end_i,
  input  wire logic [ptsi_pkg::NUM_WIN-1:0] win_match_i,
  input  wire ptsi_pkg::ptsi_pair_t       pair_mode_i,
  input  wire logic                       rom_match_i,
  input  wire logic                       wide_ack_i,
  input  wire logic                       dual_addr_i,
  input  wire logic                       frame_n_i,
  input  wire logic                       irdy_n_i,
  input  wire logic                       trdy_n_i,
  input  wire logic                       local_irq_n_i,
  input  wire logic [ptsi_pkg::CMD_W-1:0] command_i,
  output logic [ptsi_pkg::STATUS_W-1:0]   target_status_bus_o,
  output logic                            inta_n_o
);
  import ptsi_pkg::*;

  // ------------------------------------------------------------
  // Window decode
  // ------------------------------------------------------------
  ptsi_claim_if claim ();

  assign claim.win_match = win_match_i;
  assign claim.pair_mode = pair_mode_i;

  ptsi_win_decode u_dec
  (
    .claim (claim)
  );

  // ------------------------------------------------------------
  // Transaction state
  // ------------------------------------------------------------
  typedef enum logic [1:0]
  {
    PTSI_IDLE  = 2'b00,
    PTSI_FIRST = 2'b01,
    PTSI_DATA  = 2'b10
  } ptsi_state_t;

  ptsi_state_t               state_r;
  ptsi_state_t               state_nxt;
  logic                      busy;
  logic                      xfer;
  logic                      claim_take;
  logic                      end_take;

  // Transfer completes when both ready strobes are low
  assign xfer       = ~irdy_n_i & ~trdy_n_i;
  assign busy       = (state_r != PTSI_IDLE);
  // Claims while busy and ends while idle are refused
  assign claim_take = ~busy & claim_start_i;
  assign end_take   = busy & access_end_i;

  always_comb
  begin
    state_nxt = state_r;
    unique case (state_r)
      PTSI_IDLE:
      begin
        if (claim_start_i)
        begin
          state_nxt = PTSI_FIRST;
        end
      end
      PTSI_FIRST:
      begin
        if (access_end_i)
        begin
          state_nxt = PTSI_IDLE;
        end
        else if (xfer)
        begin
          state_nxt = PTSI_DATA;
        end
      end
      PTSI_DATA:
      begin
        if (access_end_i)
        begin
          state_nxt = PTSI_IDLE;
        end
      end
      default:
      begin
        state_nxt = PTSI_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (!reset_n_i)
    begin
      state_r <= PTSI_IDLE;
    end
    else
    begin
      state_r <= state_nxt;
    end
  end

  // ------------------------------------------------------------
  // Claim bits: captured with the claim, cleared at the end
  // ------------------------------------------------------------
  logic [STATUS_W-1:0]       claim_r;
  logic [STATUS_W-1:0]       claim_nxt;

  always_comb
  begin
    claim_nxt = claim_r;
    if (claim_take)
    begin
      claim_nxt                       = STATUS_RST;
      claim_nxt[NUM_WIN-1:BIT_WIN_LO] = claim.win_hit;
      claim_nxt[BIT_ROM_HIT]          = rom_match_i;
      // Narrow variants leave the width bit reserved at zero
      claim_nxt[BIT_WIDE]             = WIDE_BUS & wide_ack_i;
      claim_nxt[BIT_ACCESS]           = 1'b1;
      claim_nxt[BIT_DUAL_ADDR]        = dual_addr_i;
    end
    else if (end_take | ~busy)
    begin
      // Nothing survives the end, so local logic sees no stale claim
      claim_nxt = STATUS_RST;
    end
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (!reset_n_i)
    begin
      claim_r <= STATUS_RST;
    end
    else
    begin
      claim_r <= claim_nxt;
    end
  end

  // ------------------------------------------------------------
  // Burst flag
  // ------------------------------------------------------------
  logic                      burst_r;
  logic                      burst_nxt;

  always_comb
  begin
    burst_nxt = burst_r;
    if (~busy | end_take)
    begin
      burst_nxt = 1'b0;
    end
    else if ((state_r == PTSI_FIRST) & ~irdy_n_i)
    begin
      // Frame still low with irdy in the first data phase: more phases follow
      burst_nxt = ~frame_n_i;
    end
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (!reset_n_i)
    begin
      burst_r <= STATUS_RST[BIT_BURST];
    end
    else
    begin
      burst_r <= burst_nxt;
    end
  end

  // ------------------------------------------------------------
  // Transfer pulse
  // ------------------------------------------------------------
  logic                      xfer_r;
  logic                      xfer_nxt;

  always_comb
  begin
    // Only transfers of a claimed access count, the ending cycle included
    xfer_nxt = busy & xfer;
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (!reset_n_i)
    begin
      xfer_r <= STATUS_RST[BIT_XFER];
    end
    else
    begin
      xfer_r <= xfer_nxt;
    end
  end

  // ------------------------------------------------------------
  // Interrupt forwarding
  // ------------------------------------------------------------
  logic                      inta_n_r;
  logic                      inta_n_nxt;

  always_comb
  begin
    // Registered, so the line trails the request by one clock
    inta_n_nxt = ~(~local_irq_n_i & ~command_i[CMD_INT_DIS]);
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (!reset_n_i)
    begin
      inta_n_r <= INTA_RST_N;
    end
    else
    begin
      inta_n_r <= inta_n_nxt;
    end
  end

  // ------------------------------------------------------------
  // Outputs: each status bit is a flop of its own group
  // ------------------------------------------------------------
  logic [STATUS_W-1:0]       status_out;

  always_comb
  begin
    status_out            = claim_r;
    status_out[BIT_BURST] = burst_r;
    status_out[BIT_XFER]  = xfer_r;
  end

  assign target_status_bus_o = status_out;
  assign inta_n_o            = inta_n_r;
endmodule

// ### rtl/ptsi_win_decode.sv
// Window hit decoder with 64-bit pairing
`timescale 1ns/1ps
module ptsi_win_decode
  import ptsi_pkg::*;
(
  ptsi_claim_if.decoder claim
);
  always_comb
  begin
    claim.win_hit = claim.win_match;
    unique case (claim.pair_mode)
      PTSI_PAIR_01:
      begin
        // A paired window hits on either half; report both bits
        claim.win_hit[0] = claim.win_match[0] | claim.win_match[1];
        claim.win_hit[1] = claim.win_match[0] | claim.win_match[1];
      end
      PTSI_PAIR_12:
      begin
        claim.win_hit[1] = claim.win_match[1] | claim.win_match[2];
        claim.win_hit[2] = claim.win_match[1] | claim.win_match[2];
      end
      PTSI_PAIR_NONE:
      begin
        claim.win_hit = claim.win_match;
      end
      default:
      begin
        claim.win_hit = claim.win_match;
      end
    endcase
  end
endmodule

// ### sim/ptsi_local_model.sv
// Local-side interrupt source model
`timescale 1ns/1ps
module ptsi_local_model
(
  input  wire logic clk_sys_i,
  input  wire logic reset_n_i,
  input  wire logic irq_want_i,
  output logic      local_irq_n_o
);
  // Registered so the request never glitches; inactive whenever idle
  always_ff @(posedge clk_sys_i)
    local_irq_n_o <= !(reset_n_i && irq_want_i);
endmodule

// ### sim/ptsi_properties.sv
// Assertion checker for the target status and interrupt block
`timescale 1ns/1ps
module ptsi_properties
  import ptsi_pkg::*;
#(
  parameter bit WIDE_BUS = 1'b1
)
(
  input wire logic        clk_sys_i,
  input wire logic        reset_n_i,
  input wire logic        claim_start_i,
  input wire logic        access_end_i,
  input wire logic [5:0]  win_match_i,
  input wire ptsi_pair_t  pair_mode_i,
  input wire logic        rom_match_i,
  input wire logic        wide_ack_i,
  input wire logic        dual_addr_i,
  input wire logic        frame_n_i,
  input wire logic        irdy_n_i,
  input wire logic        trdy_n_i,
  input wire logic        local_irq_n_i,
  input wire logic [15:0] command_i,
  input wire logic [11:0] target_status_bus_o,
  input wire logic        inta_n_o
);
  logic act_r;
  wire [5:0] w = win_match_i;
  wire [11:0] st = target_status_bus_o;
  wire p1 = pair_mode_i == PTSI_PAIR_01;
  wire p2 = pair_mode_i == PTSI_PAIR_12;
  wire [5:0] hit = w | {3'h0, p2 & w[1], p1 & w[0] | p2 & w[2], p1 & w[1]};
  wire irq_q = local_irq_n_i | command_i[CMD_INT_DIS];
  wire xf = act_r & !irdy_n_i & !trdy_n_i;
  // Own copy of the busy state, so claim bits are judged against it
  always_ff @(posedge clk_sys_i)
    act_r <= reset_n_i && (act_r ? !access_end_i : claim_start_i);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!reset_n_i);
  sequence s_claim; claim_start_i && !act_r; endsequence
  sequence s_first; $rose(st[8]) && !frame_n_i && !irdy_n_i; endsequence
  property p_irq; $past(reset_n_i) |-> inta_n_o == $past(irq_q); endproperty
  a_irq: assert property (p_irq) else $error("inta mismatch");
  property p_hit; s_claim |=> st[5:0] == $past(hit); endproperty
  a_hit: assert property (p_hit) else $error("window hit mismatch");
  property p_rom; s_claim |=> st[6] == $past(rom_match_i); endproperty
  a_rom: assert property (p_rom) else $error("rom hit mismatch");
  property p_wide; s_claim |=> st[7] == (WIDE_BUS & $past(wide_ack_i)); endproperty
  a_wide: assert property (p_wide) else $error("width bit mismatch");
  property p_acc; st[8] == act_r; endproperty
  a_acc: assert property (p_acc) else $error("access mismatch");
  property p_burst; s_first |=> st[9]; endproperty
  a_burst: assert property (p_burst) else $error("burst missing");
  property p_xfer; $past(reset_n_i) |-> st[10] == $past(xf); endproperty
  a_xfer: assert property (p_xfer) else $error("transfer mismatch");
  property p_dual; s_claim |=> st[11] == $past(dual_addr_i); endproperty
  a_dual: assert property (p_dual) else $error("dual mismatch");
  property p_idle; !act_r |-> (st & 12'hbff) == 12'h000; endproperty
  a_idle: assert property (p_idle) else $error("stale claim");
endmodule
bind ptsi_top ptsi_properties #(.WIDE_BUS(WIDE_BUS)) ptsi_properties_inst
(
  .clk_sys_i           (clk_sys_i),
  .reset_n_i           (reset_n_i),
  .claim_start_i       (claim_start_i),
  .access_end_i        (access_end_i),
  .win_match_i         (win_match_i),
  .pair_mode_i         (pair_mode_i),
  .rom_match_i         (rom_match_i),
  .wide_ack_i          (wide_ack_i),
  .dual_addr_i         (dual_addr_i),
  .frame_n_i           (frame_n_i),
  .irdy_n_i            (irdy_n_i),
  .trdy_n_i            (trdy_n_i),
  .local_irq_n_i       (local_irq_n_i),
  .command_i           (command_i),
  .target_status_bus_o (target_status_bus_o),
  .inta_n_o            (inta_n_o)
);

// ### sim/tb_pci_target_status_and_irq.sv
// Bench for the target status and interrupt block
`timescale 1ns/1ps
module tb_pci_target_status_and_irq;
  import ptsi_pkg::*;
  logic clk_sys_i = 1'h0, reset_n_i = 1'h0, claim_start_i = 1'h0, access_end_i = 1'h0;
  logic rom_match_i = 1'h0, wide_ack_i = 1'h0, dual_addr_i = 1'h0, frame_n_i = 1'h1;
  logic irdy_n_i = 1'h1, trdy_n_i = 1'h1, want = 1'h0, local_irq_n_i, inta_n_o;
  logic [5:0] win_match_i = 6'h00;
  logic [15:0] command_i = 16'h0000;
  logic [11:0] target_status_bus_o;
  logic [11:0] narrow_status;
  ptsi_pair_t pair_mode_i = PTSI_PAIR_NONE;
  int n_fail = 0, compares = 0;
  always #50 clk_sys_i = ~clk_sys_i;
  ptsi_top ptsi_top_inst
  (
    .clk_sys_i           (clk_sys_i),
    .reset_n_i           (reset_n_i),
    .claim_start_i       (claim_start_i),
    .access_end_i        (access_end_i),
    .win_match_i         (win_match_i),
    .pair_mode_i         (pair_mode_i),
    .rom_match_i         (rom_match_i),
    .wide_ack_i          (wide_ack_i),
    .dual_addr_i         (dual_addr_i),
    .frame_n_i           (frame_n_i),
    .irdy_n_i            (irdy_n_i),
    .trdy_n_i            (trdy_n_i),
    .local_irq_n_i       (local_irq_n_i),
    .command_i           (command_i),
    .target_status_bus_o (target_status_bus_o),
    .inta_n_o            (inta_n_o)
  );
  // Narrow variant sees the same inputs; only its width bit must differ
  if (1'b1)
  begin : g_narrow
    ptsi_top #(.WIDE_BUS(1'b0)) ptsi_top_inst
    (
      .clk_sys_i           (clk_sys_i),
      .reset_n_i           (reset_n_i),
      .claim_start_i       (claim_start_i),
      .access_end_i        (access_end_i),
      .win_match_i         (win_match_i),
      .pair_mode_i         (pair_mode_i),
      .rom_match_i         (rom_match_i),
      .wide_ack_i          (wide_ack_i),
      .dual_addr_i         (dual_addr_i),
      .frame_n_i           (frame_n_i),
      .irdy_n_i            (irdy_n_i),
      .trdy_n_i            (trdy_n_i),
      .local_irq_n_i       (local_irq_n_i),
      .command_i           (command_i),
      .target_status_bus_o (narrow_status),
      .inta_n_o            ()
    );
  end
  ptsi_local_model ptsi_local_model_inst
  (
    .clk_sys_i     (clk_sys_i),
    .reset_n_i     (reset_n_i),
    .irq_want_i    (want),
    .local_irq_n_o (local_irq_n_i)
  );
  task automatic chk(input logic [11:0] got, exp);
    compares++;
    if (got !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED at %0t: %h not %h", $time, got, exp);
    end
  endtask
  task automatic chk_inta(input logic got, exp);
    compares++;
    if (got !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED at %0t: inta %b not %b", $time, got, exp);
    end
  endtask
  // Second claim in mid-access must be ignored, so it carries other windows
  task automatic xact(input logic [5:0] w, e, input ptsi_pair_t p, input logic r, d);
    @(negedge clk_sys_i);
    {claim_start_i, win_match_i, rom_match_i, wide_ack_i, dual_addr_i} = {1'h1, w, r, !r, d};
    pair_mode_i = p;
    @(negedge clk_sys_i);
    chk(target_status_bus_o, {d, 3'h1, !r, r, e});
    chk(narrow_status, {d, 3'h1, 1'h0, r, e});
    {win_match_i, frame_n_i, irdy_n_i, trdy_n_i} = {~w, d, 2'h0};
    @(negedge clk_sys_i);
    chk(target_status_bus_o, {d, 1'h1, !d, 1'h1, !r, r, e});
    {claim_start_i, access_end_i, frame_n_i, irdy_n_i, trdy_n_i} = 5'h0f;
    @(negedge clk_sys_i);
    chk(target_status_bus_o, 12'h000);
    access_end_i = 1'h0;
    $display("claim test done");
  endtask
  task automatic irq(input logic q, dis);
    @(negedge clk_sys_i);
    want = q;
    command_i[CMD_INT_DIS] = dis;
    repeat (2) @(negedge clk_sys_i);
    chk_inta(inta_n_o, !(q && !dis));
    $display("irq test done");
  endtask
  task automatic close_out();
    $display("compares %0d mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial
  begin
    repeat (4) @(negedge clk_sys_i);
    chk(target_status_bus_o, 12'h000);
    chk_inta(inta_n_o, 1'h1);
    reset_n_i = 1'h1;
    $display("reset test done");
    xact(6'h01, 6'h01, PTSI_PAIR_NONE, 1'h0, 1'h0);
    xact(6'h02, 6'h03, PTSI_PAIR_01, 1'h1, 1'h1);
    xact(6'h04, 6'h06, PTSI_PAIR_12, 1'h0, 1'h1);
    xact(6'h20, 6'h20, PTSI_PAIR_12, 1'h1, 1'h0);
    // Reset in mid-access must drop every claim bit at once
    @(negedge clk_sys_i);
    {claim_start_i, win_match_i} = {1'h1, 6'h08};
    @(negedge clk_sys_i);
    {claim_start_i, reset_n_i} = 2'h0;
    @(negedge clk_sys_i);
    chk(target_status_bus_o, 12'h000);
    reset_n_i = 1'h1;
    $display("reset in access test done");
    irq(1'h1, 1'h0);
    irq(1'h1, 1'h1);
    irq(1'h0, 1'h0);
    close_out();
  end
endmodule
